//--- inc/cmp_regs.svh
// Purpose: offsets, bit positions and values of the codec memory-write and PAD registers
// Assumes: 4-bit register index, 8-bit data
// Notes: indices are used as-is on the register port
`ifndef CMP_REGS_SVH
`define CMP_REGS_SVH

`define CMP_ADDR_W 4
`define CMP_OFF_CTRL0 4'h0
`define CMP_OFF_CTRL1 4'h1
`define CMP_OFF_MADDR_HI 4'h6
`define CMP_OFF_MADDR_LO 4'h7
`define CMP_OFF_MDATA_HI 4'h8
`define CMP_OFF_MDATA_LO 4'h9
`define CMP_OFF_PAD 4'hA
`define CMP_OFF_RDYFMT 4'hB
`define CMP_OFF_SPARE 4'hC

`define CMP_B_RST 7
`define CMP_B_WCMD 7
`define CMP_B_PADEN 2
`define CMP_B_READY 7
`define CMP_B_FMT 1
`define CMP_B_SYNC_PD 0

`define CMP_RST_VAL 8'h00
`define CMP_MODE_INIT 2'h0

`define CMP_CODE_18 2'h1
`define CMP_CODE_12 2'h0
`define CMP_CODE_6 2'h3
`define CMP_DB_18 6'h12
`define CMP_DB_12 6'h0C
`define CMP_DB_6 6'h06
`define CMP_DB_0 6'h00

`endif

//--- inc/cmp_pkg.sv
// Purpose: types shared by the codec memory-write and PAD control block
// Assumes: nothing beyond the register header
// Notes: dB fields are two's complement
package cmp_pkg;

  // decoded PAD levels in dB
  typedef struct packed {
    logic signed [5:0] acoustic_send_output_db;
    logic signed [5:0] acoustic_send_input_db;
    logic signed [5:0] line_send_output_db;
    logic signed [5:0] line_send_input_db;
  } cmp_pad_s;

  // one write into the default-value memory
  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [15:0] data;
  } cmp_memwr_s;

endpackage : cmp_pkg

//--- rtl/cmp_ctrl_regs.sv
// Purpose: control registers for memory writes, PAD levels, write-ready and coding format
// Assumes: all inputs synchronous to clk_sys_in; read data one cycle after the strobe
// Notes: any reset source clears control registers and the ready flag, but read data, mulaw and PAD-on flags only on srst_in; the reset bit clears itself
`timescale 1ns/10ps
`include "cmp_regs.svh"

module cmp_ctrl_regs
  import cmp_pkg::*;
#(
  parameter int MEM_AW = 16
) (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic powerdown_reset_control_n_in,
  input wire logic pad_enable_pin_in,
  input wire logic coding_format_pin_in,
  input wire logic [`CMP_ADDR_W-1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  output cmp_pad_s pad_out,
  output logic pad_on_out,
  output logic mulaw_sel_out,
  output logic write_ready_out,
  output logic sync_powerdown_out,
  output cmp_memwr_s mem_wr_out
);

  // decode one two-bit PAD code to its dB magnitude
  function automatic logic signed [5:0] pad_db(input logic [1:0] code);
    logic signed [5:0] db;
    db = `CMP_DB_0;
    unique case (code)
      `CMP_CODE_18: db = `CMP_DB_18;
      `CMP_CODE_12: db = `CMP_DB_12;
      `CMP_CODE_6: db = `CMP_DB_6;
      default: db = `CMP_DB_0;
    endcase
    return db;
  endfunction : pad_db

  logic rst_int;
  logic rst_bit_r;
  logic [1:0] mode_r;
  logic cmd_r;
  logic pad_en_bit_r;
  logic [7:0] addr_hi_r;
  logic [7:0] addr_lo_r;
  logic [7:0] data_hi_r;
  logic [7:0] data_lo_r;
  logic [7:0] pad_lvl_r;
  logic fmt_bit_r;
  logic sync_pd_r;
  logic [7:0] rdata_r;
  cmp_pad_s pad_r;
  logic pad_on_r;
  logic mulaw_r;
  logic ready_r;
  cmp_memwr_s mem_wr_r;
  logic init_mode;
  logic pad_en;
  logic cmd_set;
  logic [7:0] rd_mux;

  // write decodes
  function automatic logic wr_at(input logic [`CMP_ADDR_W-1:0] off);
    return reg_wr_in && (reg_addr_in == off);
  endfunction : wr_at

  assign rst_int = srst_in || !powerdown_reset_control_n_in || rst_bit_r;
  assign init_mode = (mode_r == `CMP_MODE_INIT);
  assign pad_en = pad_enable_pin_in || pad_en_bit_r;
  assign cmd_set = wr_at(`CMP_OFF_CTRL1) && reg_wdata_in[`CMP_B_WCMD];

  // control 0: reset bit pulses, mode bits steer the ready flag
  always_ff @(posedge clk_sys_in) begin
    if (rst_int) begin
      rst_bit_r <= 1'b0;
      mode_r <= `CMP_MODE_INIT;
    end else if (wr_at(`CMP_OFF_CTRL0)) begin
      rst_bit_r <= reg_wdata_in[`CMP_B_RST];
      mode_r <= reg_wdata_in[1:0];
    end
  end

  // control 1: PAD enable bit
  always_ff @(posedge clk_sys_in) begin
    if (rst_int) begin
      pad_en_bit_r <= 1'b0;
    end else if (wr_at(`CMP_OFF_CTRL1)) begin
      pad_en_bit_r <= reg_wdata_in[`CMP_B_PADEN];
    end
  end

  // command self-clears, a new set wins
  always_ff @(posedge clk_sys_in) begin
    if (rst_int) begin
      cmd_r <= 1'b0;
    end else if (cmd_set) begin
      cmd_r <= 1'b1;
    end else if (cmd_r) begin
      cmd_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_int) begin
      addr_hi_r <= `CMP_RST_VAL;
      addr_lo_r <= `CMP_RST_VAL;
    end else begin
      if (wr_at(`CMP_OFF_MADDR_HI)) begin
        addr_hi_r <= reg_wdata_in;
      end
      if (wr_at(`CMP_OFF_MADDR_LO)) begin
        addr_lo_r <= reg_wdata_in;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_int) begin
      data_hi_r <= `CMP_RST_VAL;
      data_lo_r <= `CMP_RST_VAL;
    end else begin
      if (wr_at(`CMP_OFF_MDATA_HI)) begin
        data_hi_r <= reg_wdata_in;
      end
      if (wr_at(`CMP_OFF_MDATA_LO)) begin
        data_lo_r <= reg_wdata_in;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_int) begin
      pad_lvl_r <= `CMP_RST_VAL;
    end else if (wr_at(`CMP_OFF_PAD)) begin
      pad_lvl_r <= reg_wdata_in;
    end
  end

  // format and sync power-down bits, reserved bits dropped
  always_ff @(posedge clk_sys_in) begin
    if (rst_int) begin
      fmt_bit_r <= 1'b0;
      sync_pd_r <= 1'b0;
    end else if (wr_at(`CMP_OFF_RDYFMT)) begin
      fmt_bit_r <= reg_wdata_in[`CMP_B_FMT];
      sync_pd_r <= reg_wdata_in[`CMP_B_SYNC_PD];
    end
  end

  // read multiplexer; spare and unmapped read zero
  always_comb begin
    rd_mux = `CMP_RST_VAL;
    unique case (reg_addr_in)
      `CMP_OFF_CTRL0: rd_mux = {rst_bit_r, 5'h00, mode_r};
      `CMP_OFF_CTRL1: rd_mux = {cmd_r, 4'h0, pad_en_bit_r, 2'h0};
      `CMP_OFF_MADDR_HI: rd_mux = addr_hi_r;
      `CMP_OFF_MADDR_LO: rd_mux = addr_lo_r;
      `CMP_OFF_MDATA_HI: rd_mux = data_hi_r;
      `CMP_OFF_MDATA_LO: rd_mux = data_lo_r;
      `CMP_OFF_PAD: rd_mux = pad_lvl_r;
      `CMP_OFF_RDYFMT: rd_mux = {init_mode, 5'h00, fmt_bit_r, sync_pd_r};
      default: rd_mux = `CMP_RST_VAL;
    endcase
  end

  // read data stands one cycle after the strobe
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      rdata_r <= `CMP_RST_VAL;
    end else if (reg_rd_in) begin
      rdata_r <= rd_mux;
    end else begin
      rdata_r <= `CMP_RST_VAL;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_int || !pad_en) begin
      pad_r <= '0;
    end else begin
      pad_r.acoustic_send_output_db <= pad_db(pad_lvl_r[7:6]);
      pad_r.acoustic_send_input_db <= -pad_db(pad_lvl_r[5:4]);
      pad_r.line_send_output_db <= pad_db(pad_lvl_r[3:2]);
      pad_r.line_send_input_db <= -pad_db(pad_lvl_r[1:0]);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      mulaw_r <= 1'b0;
      pad_on_r <= 1'b0;
      ready_r <= 1'b0;
    end else begin
      mulaw_r <= fmt_bit_r || coding_format_pin_in;
      pad_on_r <= pad_en;
      ready_r <= init_mode && !rst_int;
    end
  end

  // issue the memory write, refused outside initial mode
  always_ff @(posedge clk_sys_in) begin
    if (rst_int) begin
      mem_wr_r <= '0;
    end else begin
      mem_wr_r.we <= cmd_r && init_mode;
      if (cmd_r) begin
        mem_wr_r.addr <= {addr_hi_r, addr_lo_r};
        mem_wr_r.data <= {data_hi_r, data_lo_r};
      end
    end
  end

  assign reg_rdata_out = rdata_r;
  assign pad_out = pad_r;
  assign pad_on_out = pad_on_r;
  assign mulaw_sel_out = mulaw_r;
  assign write_ready_out = ready_r;
  assign sync_powerdown_out = sync_pd_r;
  assign mem_wr_out = mem_wr_r;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_int);

  sequence s_cmd;
    cmd_set ##1 (init_mode && !cmd_set);
  endsequence

  property p_addr;
    mem_wr_r.we |-> mem_wr_r.addr == {$past(addr_hi_r), $past(addr_lo_r)};
  endproperty
  a_addr: assert property (p_addr) else $error("memory address not staged bytes");

  property p_data;
    mem_wr_r.we |-> mem_wr_r.data == {$past(data_hi_r), $past(data_lo_r)};
  endproperty
  a_data: assert property (p_data) else $error("memory data not staged bytes");

  // codes step in 6 dB: magnitude is 6 * {~hi, lo}, independent of the decode function
  property p_ac_out;
    pad_en |=> pad_r.acoustic_send_output_db == 6'(6 * $past({~pad_lvl_r[7], pad_lvl_r[6]}));
  endproperty
  a_ac_out: assert property (p_ac_out) else $error("acoustic output gain wrong");

  property p_ac_in;
    pad_en |=> pad_r.acoustic_send_input_db == 6'h00 - 6'(6 * $past({~pad_lvl_r[5], pad_lvl_r[4]}));
  endproperty
  a_ac_in: assert property (p_ac_in) else $error("acoustic input loss wrong");

  property p_ln_out;
    pad_en |=> pad_r.line_send_output_db == 6'(6 * $past({~pad_lvl_r[3], pad_lvl_r[2]}));
  endproperty
  a_ln_out: assert property (p_ln_out) else $error("line output gain wrong");

  property p_ln_in;
    pad_en |=> pad_r.line_send_input_db == 6'h00 - 6'(6 * $past({~pad_lvl_r[1], pad_lvl_r[0]}));
  endproperty
  a_ln_in: assert property (p_ln_in) else $error("line input loss wrong");

  property p_pad_off;
    !pad_enable_pin_in && !pad_en_bit_r |=> pad_r == '0 && !pad_on_r;
  endproperty
  a_pad_off: assert property (p_pad_off) else $error("PAD applied while off");

  property p_ready;
    reg_rd_in && reg_addr_in == `CMP_OFF_RDYFMT |=> reg_rdata_out[`CMP_B_READY] == $past(mode_r == 2'h0);
  endproperty
  a_ready: assert property (p_ready) else $error("ready flag wrong");

  property p_fmt;
    ##1 mulaw_sel_out == ($past(fmt_bit_r) || $past(coding_format_pin_in));
  endproperty
  a_fmt: assert property (p_fmt) else $error("coding format not bit OR pin");

  property p_rst;
    rst_int |=> addr_hi_r == 8'h00 && pad_lvl_r == 8'h00 && mode_r == 2'h0 && !cmd_r && !fmt_bit_r;
  endproperty
  a_rst: assert property (disable iff (1'b0) p_rst) else $error("register not cleared by reset");

  property p_refuse;
    cmd_r && !init_mode |=> !mem_wr_r.we;
  endproperty
  a_refuse: assert property (p_refuse) else $error("memory write outside initial mode");

  property p_wcmd;
    s_cmd |=> mem_wr_r.we && !cmd_r ##1 !mem_wr_r.we;
  endproperty
  a_wcmd: assert property (p_wcmd) else $error("write command sequence wrong");

  property p_sync_pd;
    wr_at(`CMP_OFF_RDYFMT) ##1 reg_rd_in && reg_addr_in == `CMP_OFF_RDYFMT && !reg_wr_in
      |=> reg_rdata_out[`CMP_B_SYNC_PD] == $past(reg_wdata_in[`CMP_B_SYNC_PD], 2);
  endproperty
  a_sync_pd: assert property (p_sync_pd) else $error("sync power-down bit lost");

  property p_rdback;
    wr_at(`CMP_OFF_PAD) ##1 reg_rd_in && reg_addr_in == `CMP_OFF_PAD && !reg_wr_in
      |=> reg_rdata_out == $past(reg_wdata_in, 2);
  endproperty
  a_rdback: assert property (p_rdback) else $error("PAD levels do not read back");

endmodule : cmp_ctrl_regs

//--- tb/cmp_host_model.sv
// Purpose: microcomputer model that drives the register port
// Assumes: read data stands only in the cycle after the read strobe
// Notes: tasks are called from the test top
`timescale 1ns/10ps
`include "cmp_regs.svh"
module cmp_host_model (
  input wire logic clk_sys_in,
  input wire logic [7:0] reg_rdata_in,
  output logic [`CMP_ADDR_W-1:0] reg_addr_out,
  output logic [7:0] reg_wdata_out,
  output logic reg_wr_out,
  output logic reg_rd_out
);
  // idle bus at time zero
  initial begin
    reg_addr_out = 4'h0;
    reg_wdata_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
  end

  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr_out <= a;
    reg_wdata_out <= d;
    reg_wr_out <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_out <= 1'b0;
  endtask : wr

  // one-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr_out <= a;
    reg_rd_out <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_out <= 1'b0;
    #1;
    d = reg_rdata_in;
  endtask : rd

  // write then read back with no gap between the strobes
  task automatic wr_rd(input logic [3:0] a, input logic [7:0] dw, output logic [7:0] dr);
    @(posedge clk_sys_in);
    reg_addr_out <= a;
    reg_wdata_out <= dw;
    reg_wr_out <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_out <= 1'b0;
    reg_rd_out <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_out <= 1'b0;
    #1;
    dr = reg_rdata_in;
  endtask : wr_rd

  // matched gain and loss, acoustic and line codes apart
  task automatic pad_set(input logic [1:0] ca, input logic [1:0] cl);
    wr(`CMP_OFF_PAD, {ca, ca, cl, cl});
  endtask : pad_set

  // reserved bits kept zero, register read straight back
  task automatic fmt_set(input logic f, input logic s, output logic [7:0] d);
    wr_rd(`CMP_OFF_RDYFMT, {6'h00, f, s}, d);
  endtask : fmt_set

  task automatic dev_reset();
    wr(`CMP_OFF_CTRL0, 8'h80);
  endtask : dev_reset

  // ready checked, address, data, then command
  task automatic mem_write(input logic [15:0] a, input logic [15:0] d, output logic sent);
    logic [7:0] s;
    rd(`CMP_OFF_RDYFMT, s);
    sent = s[`CMP_B_READY];
    if (sent === 1'b1) begin
      wr(`CMP_OFF_MADDR_HI, a[15:8]);
      wr(`CMP_OFF_MADDR_LO, a[7:0]);
      wr(`CMP_OFF_MDATA_HI, d[15:8]);
      wr(`CMP_OFF_MDATA_LO, d[7:0]);
      wr(`CMP_OFF_CTRL1, 8'h80);
    end
  endtask : mem_write
endmodule : cmp_host_model

//--- tb/cmp_ctrl_regs_test.sv
// Purpose: self-checking bench for the codec control registers
// Assumes: host model drives the register port
// Notes: fixed seed; expectations come from the field codes
`timescale 1ns/10ps
`include "cmp_regs.svh"
module cmp_ctrl_regs_test
  import cmp_pkg::*;
;
  logic clk_sys_in = 1'b0;
  logic srst_in = 1'b1;
  logic powerdown_reset_control_n_in = 1'b1;
  logic pad_enable_pin_in = 1'b0;
  logic coding_format_pin_in = 1'b0;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_wr;
  logic reg_rd;
  cmp_pad_s pad_out;
  logic pad_on_out;
  logic mulaw_sel_out;
  logic write_ready_out;
  logic sync_powerdown_out;
  cmp_memwr_s mem_wr_out;
  cmp_memwr_s last_wr;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int we_cnt = 0;
  int seed = 32'hF0B4;

  // 200 MHz clock
  always #2.5 clk_sys_in = ~clk_sys_in;

  cmp_ctrl_regs dut (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .powerdown_reset_control_n_in(powerdown_reset_control_n_in),
    .pad_enable_pin_in(pad_enable_pin_in), .coding_format_pin_in(coding_format_pin_in),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(reg_rdata), .pad_out(pad_out), .pad_on_out(pad_on_out), .mulaw_sel_out(mulaw_sel_out),
    .write_ready_out(write_ready_out), .sync_powerdown_out(sync_powerdown_out), .mem_wr_out(mem_wr_out));

  cmp_host_model host (.clk_sys_in(clk_sys_in), .reg_rdata_in(reg_rdata), .reg_addr_out(reg_addr),
    .reg_wdata_out(reg_wdata), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd));

  // count memory write pulses and keep the last one
  always @(posedge clk_sys_in) begin
    if (mem_wr_out.we === 1'b1) begin
      we_cnt <= we_cnt + 1;
      last_wr <= mem_wr_out;
    end
  end

  // hang guard
  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      results();
    end
  end

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // output gain in dB for a two-bit code
  function automatic logic [5:0] gain(input logic [1:0] c);
    case (c)
      2'h1: gain = 6'h12;
      2'h0: gain = 6'h0C;
      2'h3: gain = 6'h06;
      default: gain = 6'h00;
    endcase
  endfunction : gain

  function automatic cmp_pad_s exp_pad(input logic [1:0] ca, input logic [1:0] cl, input logic on);
    logic [5:0] ga;
    logic [5:0] gl;
    ga = on ? gain(ca) : 6'h00;
    gl = on ? gain(cl) : 6'h00;
    exp_pad = {ga, 6'h00 - ga, gl, 6'h00 - gl};
  endfunction : exp_pad

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : settle

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results

  // main sequence
  initial begin
    logic [7:0] d;
    logic [7:0] v;
    logic [3:0] a;
    logic [15:0] ma;
    logic [15:0] md;
    logic sent;
    int n;
    repeat (6) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    settle(1);
    chk(write_ready_out, 1'b1);
    for (a = 4'h6; a <= 4'hC; a++) begin
      host.rd(a, d);
      chk(d, (a == 4'hB) ? 8'h80 : 8'h00);
    end
    host.rd(4'h3, d);
    chk(d, 8'h00);
    for (a = 4'h6; a <= 4'hA; a++) begin
      v = 8'($random(seed));
      host.wr_rd(a, v, d);
      chk(d, v);
    end
    repeat (4) begin
      ma = 16'($random(seed));
      md = 16'($random(seed));
      n = we_cnt;
      host.mem_write(ma, md, sent);
      settle(3);
      chk(sent, 1'b1);
      chk(33'(we_cnt), 33'(n + 1));
      chk(last_wr, {1'b1, ma, md});
      host.rd(`CMP_OFF_CTRL1, d);
      chk(d[7], 1'b0);
    end
    host.wr(`CMP_OFF_CTRL0, 8'h01);
    settle(2);
    chk(write_ready_out, 1'b0);
    n = we_cnt;
    host.wr(`CMP_OFF_CTRL1, 8'h80);
    settle(4);
    chk(33'(we_cnt), 33'(n));
    host.dev_reset();
    settle(2);
    chk(write_ready_out, 1'b1);
    host.rd(`CMP_OFF_MADDR_HI, d);
    chk(d, 8'h00);
    for (int c = 0; c < 4; c++) begin
      host.pad_set(c[1:0], ~c[1:0]);
      for (int e = 0; e < 4; e++) begin
        pad_enable_pin_in <= e[0];
        host.wr(`CMP_OFF_CTRL1, {5'h00, e[1], 2'h0});
        settle(2);
        chk(pad_on_out, |e[1:0]);
        chk(pad_out, exp_pad(c[1:0], ~c[1:0], |e[1:0]));
      end
    end
    for (int f = 0; f < 3; f++) begin
      coding_format_pin_in <= f[0];
      host.fmt_set(f[1], f[0], d);
      settle(1);
      chk(mulaw_sel_out, f[0] | f[1]);
      chk(sync_powerdown_out, f[0]);
      chk(d, {1'b1, 5'h00, f[1], f[0]});
      host.dev_reset();
    end
    coding_format_pin_in <= 1'b0;
    host.wr(`CMP_OFF_MDATA_LO, 8'hA5);
    powerdown_reset_control_n_in <= 1'b0;
    settle(2);
    chk(write_ready_out, 1'b0);
    powerdown_reset_control_n_in <= 1'b1;
    host.rd(`CMP_OFF_MDATA_LO, d);
    chk(d, 8'h00);
    results();
  end
endmodule : cmp_ctrl_regs_test
